//--- rtl/ahs_axis_homing_sequencer.sv
// single-axis homing and motion sequencer with wishbone registers
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ahs_axis_homing_sequencer #(
    parameter logic AXIS_ID = 1'b0
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ahs_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // machine switches
    input wire logic dog_i,
    input wire logic home_i,
    input wire logic lim_up_i,
    input wire logic lim_lo_i,
    input wire logic switch_i,
    // drive side
    output logic [15:0] speed_o,
    output logic dir_o,
    output logic drive_en_o,
    output logic [31:0] pos_o,
    output logic busy_o,
    output logic done_o,
    output logic homed_o
);
    import ahs_pkg::*;

    typedef struct packed {
        ahs_state_e st;
        ahs_state_e rnext;
        logic [15:0] rtgt;
        logic dir;
        logic [15:0] spd;
        logic [15:0] tgt;
        logic [31:0] pos;
        logic [31:0] goal;
        logic [1:0] rev;
        logic armed;
        logic homed;
        logic drv_en;
        logic busy;
        logic done;
        logic [7:0] err;
        logic [2:0] method;
        logic hdir;
        logic [31:0] origin;
        logic [15:0] hi;
        logic [15:0] lo;
        logic [15:0] acc;
        logic [15:0] opspd;
        logic [31:0] opgoal;
        logic incr;
        logic sdir;
        logic ack;
        logic [31:0] rdat;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
    } ahs_q_s;
    ahs_q_s q_r;
    ahs_q_s q_nxt;
    logic fix;
    logic cmd_wr;
    logic [7:0] ecode;
    logic homing;
    logic dog;
    logic dog_rise;
    logic home_rise;
    logic lim_rise;
    logic lim_fall;
    logic sw_rise;
    logic [4:0] pins;
    function automatic logic [15:0] ahs_ramp(input logic [15:0] c, input logic [15:0] t,
                                             input logic [15:0] a);
        if (c < t) begin
            ahs_ramp = (t - c > a) ? c + a : t;
        end else begin
            ahs_ramp = (c - t > a) ? c - a : t;
        end
    endfunction : ahs_ramp
    function automatic logic [31:0] ahs_merge(input logic [31:0] o, input logic [31:0] d,
                                              input logic [3:0] s);
        ahs_merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) ahs_merge[i*8+:8] = d[i*8+:8];
        end
    endfunction : ahs_merge
    assign pins = {switch_i, lim_lo_i, lim_up_i, home_i, dog_i};
    // edges compare the second and third stages; a pulse shorter than a clock may vanish
    assign dog = q_r.s2[0];
    assign dog_rise = q_r.s2[0] && !q_r.s3[0];
    assign homing = (q_r.st == S_HIGH) || (q_r.st == S_DEC) || (q_r.st == S_LOW)
                    || (q_r.st == S_REV);
    // origin input is looked at only while a search runs
    assign home_rise = homing && q_r.s2[1] && !q_r.s3[1];
    assign lim_rise = (q_r.s2[2] | q_r.s2[3]) && !(q_r.s3[2] | q_r.s3[3]);
    assign lim_fall = !(q_r.s2[2] | q_r.s2[3]) && (q_r.s3[2] | q_r.s3[3]);
    assign sw_rise = q_r.s2[4] && !q_r.s3[4];
    always_comb begin
        logic [31:0] w;
        logic [31:0] g;
        logic [31:0] rem;
        logic [3:0] c;
        w = '0;
        g = '0;
        rem = '0;
        c = wb_dat_i[3:0];
        q_nxt = q_r;
        fix = 1'b0;
        cmd_wr = 1'b0;
        ecode = ERR_NONE;
        q_nxt.s1 = pins;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
        // one-cycle ack, dropped after each beat so every access sees a gap
        q_nxt.ack = 1'b0;
        if (wb_cyc_i && wb_stb_i && !q_r.ack) begin
            q_nxt.ack = 1'b1;
            q_nxt.rdat = '0;
            if (wb_we_i) begin
                // search parameters stay as written until the host changes them
                if (wb_adr_i == OFS_CMD) begin
                    cmd_wr = wb_sel_i[0];
                end else if (wb_adr_i == OFS_HCFG) begin
                    w = ahs_merge({28'h0, q_r.hdir, q_r.method}, wb_dat_i, wb_sel_i);
                    q_nxt.method = w[2:0];
                    q_nxt.hdir = w[3];
                end else if (wb_adr_i == OFS_ORIGIN) begin
                    q_nxt.origin = ahs_merge(q_r.origin, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == OFS_HSPD) begin
                    {q_nxt.lo, q_nxt.hi} = ahs_merge({q_r.lo, q_r.hi}, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == OFS_ACC) begin
                    w = ahs_merge({16'h0, q_r.acc}, wb_dat_i, wb_sel_i);
                    q_nxt.acc = w[15:0];
                end else if (wb_adr_i == OFS_OPSPD) begin
                    w = ahs_merge({16'h0, q_r.opspd}, wb_dat_i, wb_sel_i);
                    q_nxt.opspd = w[15:0];
                end else if (wb_adr_i == OFS_GOAL) begin
                    q_nxt.opgoal = ahs_merge(q_r.opgoal, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == OFS_MODE) begin
                    w = ahs_merge({30'h0, q_r.sdir, q_r.incr}, wb_dat_i, wb_sel_i);
                    q_nxt.incr = w[0];
                    q_nxt.sdir = w[1];
                end
            end else begin
                if (wb_adr_i == OFS_HCFG) begin
                    q_nxt.rdat = {28'h0, q_r.hdir, q_r.method};
                end else if (wb_adr_i == OFS_ORIGIN) begin
                    q_nxt.rdat = q_r.origin;
                end else if (wb_adr_i == OFS_HSPD) begin
                    q_nxt.rdat = {q_r.lo, q_r.hi};
                end else if (wb_adr_i == OFS_ACC) begin
                    q_nxt.rdat = {16'h0, q_r.acc};
                end else if (wb_adr_i == OFS_OPSPD) begin
                    q_nxt.rdat = {16'h0, q_r.opspd};
                end else if (wb_adr_i == OFS_GOAL) begin
                    q_nxt.rdat = q_r.opgoal;
                end else if (wb_adr_i == OFS_MODE) begin
                    q_nxt.rdat = {30'h0, q_r.sdir, q_r.incr};
                end else if (wb_adr_i == OFS_STAT) begin
                    q_nxt.rdat = {8'h0, q_r.err, 4'h0, q_r.st, 3'h0, q_r.dir,
                                  q_r.drv_en, q_r.homed, q_r.done, q_r.busy};
                end else if (wb_adr_i == OFS_POS) begin
                    q_nxt.rdat = q_r.pos;
                end else if (wb_adr_i == OFS_SPEED) begin
                    q_nxt.rdat = {16'h0, q_r.spd};
                end
            end
        end
        // motion: speed ramps toward target, position integrates speed
        q_nxt.spd = ahs_ramp(q_r.spd, q_r.tgt, q_r.acc);
        if (q_r.st != S_IDLE) begin
            q_nxt.pos = q_r.dir ? q_r.pos - {16'h0, q_r.spd} : q_r.pos + {16'h0, q_r.spd};
        end
        case (q_r.st)
            S_HIGH: begin
                case (q_r.method)
                    3'd0, 3'd1: begin
                        if (dog_rise) begin
                            q_nxt.st = S_DEC;
                            q_nxt.tgt = q_r.lo;
                            q_nxt.armed = 1'b0;
                        end
                    end
                    3'd2: begin
                        if (dog_rise) begin
                            q_nxt.st = S_REV;
                            q_nxt.tgt = '0;
                            q_nxt.rev = 2'd1;
                            q_nxt.rtgt = (q_r.rev == 2'd0) ? q_r.hi : q_r.lo;
                            q_nxt.rnext = (q_r.rev == 2'd0) ? S_HIGH : S_LOW;
                        end
                    end
                    default: begin
                        if (lim_rise) begin
                            q_nxt.st = S_REV;
                            q_nxt.tgt = '0;
                            q_nxt.rtgt = q_r.lo;
                            q_nxt.rnext = S_LOW;
                        end
                    end
                endcase
            end
            S_DEC: begin
                // origin edges here are dropped on purpose
                if (q_r.spd == q_r.tgt) begin
                    q_nxt.st = S_LOW;
                end
            end
            S_REV: begin
                if (q_r.spd == 16'h0) begin
                    q_nxt.dir = !q_r.dir;
                    q_nxt.tgt = q_r.rtgt;
                    q_nxt.st = q_r.rnext;
                end
            end
            S_LOW: begin
                case (q_r.method)
                    3'd0: begin
                        if (!dog) begin
                            q_nxt.armed = 1'b1;
                        end
                        fix = home_rise && q_r.armed && !dog;
                    end
                    3'd1: fix = home_rise && dog;
                    3'd2: fix = dog_rise;
                    3'd3: fix = home_rise;
                    default: fix = lim_fall;
                endcase
                // in methods 0 and 1, a limit during the slow search turns the axis back at low speed
                if (lim_rise && q_r.method <= 3'd1 && !fix) begin
                    q_nxt.st = S_REV;
                    q_nxt.tgt = '0;
                    q_nxt.rtgt = q_r.lo;
                    q_nxt.rnext = S_LOW;
                end
            end
            S_POS: begin
                rem = q_r.dir ? q_r.pos - q_r.goal : q_r.goal - q_r.pos;
                if (rem <= {16'h0, q_r.spd}) begin
                    q_nxt.pos = q_r.goal;
                    q_nxt.spd = '0;
                    q_nxt.tgt = '0;
                    q_nxt.st = S_IDLE;
                    q_nxt.done = 1'b1;
                end
            end
            S_SPD: begin
                if (sw_rise) begin
                    g = q_r.pos + q_r.opgoal;
                    q_nxt.goal = g;
                    q_nxt.dir = $signed(g) < $signed(q_r.pos);
                    q_nxt.st = S_POS;
                end
            end
            S_STOP: begin
                if (q_r.spd == 16'h0) begin
                    q_nxt.st = S_IDLE;
                    q_nxt.done = 1'b1;
                end
            end
            default: begin
            end
        endcase
        if (fix) begin
            q_nxt.pos = q_r.origin;
            q_nxt.homed = 1'b1;
            q_nxt.spd = '0;
            q_nxt.tgt = '0;
            q_nxt.st = S_IDLE;
            q_nxt.done = 1'b1;
        end
        if (cmd_wr) begin
            if (wb_dat_i[4] != AXIS_ID) begin
                ecode = ERR_AXIS;
            end else if (c == CMD_INH) begin
                if (wb_dat_i[5]) begin
                    q_nxt.drv_en = 1'b1;
                end
                q_nxt.done = 1'b1;
                q_nxt.err = ERR_NONE;
            end else if (c == CMD_STOP) begin
                if (q_nxt.st == S_IDLE) begin
                    q_nxt.done = 1'b1;
                    q_nxt.err = ERR_NONE;
                end else begin
                    q_nxt.st = S_STOP;
                    q_nxt.tgt = '0;
                end
            end else if (c == CMD_SWSP) begin
                if (q_r.st == S_SPD) begin
                    g = q_r.pos + q_r.opgoal;
                    q_nxt.goal = g;
                    q_nxt.dir = $signed(g) < $signed(q_r.pos);
                    q_nxt.st = S_POS;
                end else begin
                    ecode = ERR_STATE;
                end
            end else if (c == CMD_SWPS) begin
                if (q_r.st == S_POS) begin
                    q_nxt.st = S_SPD;
                    q_nxt.tgt = q_r.opspd;
                end else begin
                    ecode = ERR_STATE;
                end
            end else if (q_r.st != S_IDLE) begin
                ecode = ERR_BUSY;
            end else if (!q_r.drv_en) begin
                ecode = ERR_INH;
            end else if (c == CMD_HOME && q_r.method <= METHOD_MAX) begin
                q_nxt.st = S_HIGH;
                q_nxt.dir = q_r.hdir;
                q_nxt.tgt = q_r.hi;
                q_nxt.rev = 2'd0;
                q_nxt.armed = 1'b0;
                q_nxt.homed = 1'b0;
                q_nxt.done = 1'b0;
                q_nxt.err = ERR_NONE;
            end else if (c == CMD_POS) begin
                g = q_r.incr ? q_r.pos + q_r.opgoal : q_r.opgoal;
                q_nxt.goal = g;
                q_nxt.dir = $signed(g) < $signed(q_r.pos);
                q_nxt.tgt = q_r.opspd;
                q_nxt.st = S_POS;
                q_nxt.done = 1'b0;
                q_nxt.err = ERR_NONE;
            end else if (c == CMD_SPD) begin
                q_nxt.st = S_SPD;
                q_nxt.dir = q_r.sdir;
                q_nxt.tgt = q_r.opspd;
                q_nxt.done = 1'b0;
                q_nxt.err = ERR_NONE;
            end else begin
                ecode = ERR_CMD;
            end
        end
        if (ecode != ERR_NONE) begin
            q_nxt.done = 1'b0;
            q_nxt.err = ecode;
        end
        q_nxt.busy = (q_nxt.st != S_IDLE);
    end
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            q_r <= '0;
            q_r.hi <= HI_SPD_RST;
            q_r.lo <= LO_SPD_RST;
            q_r.acc <= ACC_RST;
            q_r.opspd <= OP_SPD_RST;
        end else begin
            q_r <= q_nxt;
        end
    end
    assign wb_dat_o = q_r.rdat;
    assign wb_ack_o = q_r.ack;
    assign speed_o = q_r.spd;
    assign dir_o = q_r.dir;
    assign drive_en_o = q_r.drv_en;
    assign pos_o = q_r.pos;
    assign busy_o = q_r.busy;
    assign done_o = q_r.done;
    assign homed_o = q_r.homed;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    home_start_a: assert property ((q_r.st == S_IDLE && q_nxt.st == S_HIGH) |=>
        (q_r.dir == q_r.hdir && q_r.tgt == q_r.hi)) else $error("homing start wrong");
    dog_slow_a: assert property ((q_r.st == S_HIGH && q_r.method <= 3'd1 && dog_rise &&
        !cmd_wr) |=> (q_r.st == S_DEC && q_r.tgt == q_r.lo)) else $error("no slowdown");
    dog_hold_a: assert property ((q_r.st == S_LOW && q_r.method == 3'd0 && dog &&
        home_rise) |-> !fix) else $error("origin taken with approach on");
    dec_ign_a: assert property ((q_r.st == S_DEC && home_rise) |-> !fix)
        else $error("origin taken while slowing");
    m1_fix_a: assert property ((q_r.st == S_LOW && q_r.method == 3'd1 && dog &&
        home_rise) |-> fix) else $error("method 1 origin missed");
    dog_rev_a: assert property ((q_r.st == S_HIGH && q_r.method == 3'd2 && dog_rise &&
        q_r.rev == 2'd0 && !cmd_wr) |=> (q_r.st == S_REV && q_r.rtgt == q_r.hi))
        else $error("first reversal wrong");
    fix_load_a: assert property ((fix && !cmd_wr) |=> (q_r.pos == $past(q_r.origin) &&
        q_r.homed && q_r.st == S_IDLE && q_r.spd == 16'h0)) else $error("origin fix wrong");
    homed_keep_a: assert property ((q_r.homed && (q_r.st == S_POS || q_r.st == S_SPD))
        |=> q_r.homed) else $error("homed lost in motion");
    spd_run_a: assert property ((q_r.st == S_SPD && !cmd_wr && !sw_rise) |=>
        q_r.st == S_SPD) else $error("speed mode ended alone");
    err_done_a: assert property ((ecode != ERR_NONE) |=> (!q_r.done &&
        q_r.err == $past(ecode))) else $error("error not reported");
    inh_rel_a: assert property ((cmd_wr && wb_dat_i[5:0] == {1'b1, AXIS_ID, CMD_INH})
        |=> q_r.drv_en) else $error("inhibit not released");
endmodule : ahs_axis_homing_sequencer
`default_nettype wire

//--- rtl/ahs_pkg.sv
// constants and types for the axis homing sequencer
// Behaviour
// - method code selects one of five searches
// - fixed origin ignores origin switch afterwards
// - homing starts in set direction, high speed
// - methods 0,1: approach switch slows to low
// - method 0: origin after approach on-off
// - method 0: origin ignored while approach on
// - method 0: origin ignored during slowdown
// - method 1: origin with approach on fixes
// - method 1: origin ignored during slowdown
// - method 1: limit handled as method 0
// - method 2: approach reverses high, then low
// - method 2: approach on low pass fixes
// - method 3: limit reverses low, origin fixes
// - method 4: limit reverses low, leaving fixes
// - speed mode runs until stop command
// - switch command or input turns speed to position
// - switch command turns position to speed
// - position move absolute or incremental to goal
// - inhibit release option 0 keeps, 1 releases
// - done 1 on success, 0 with error code
package ahs_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_HCFG = 8'h04;
    localparam logic [7:0] OFS_ORIGIN = 8'h08;
    localparam logic [7:0] OFS_HSPD = 8'h0c;
    localparam logic [7:0] OFS_ACC = 8'h10;
    localparam logic [7:0] OFS_OPSPD = 8'h14;
    localparam logic [7:0] OFS_GOAL = 8'h18;
    localparam logic [7:0] OFS_MODE = 8'h1c;
    localparam logic [7:0] OFS_STAT = 8'h20;
    localparam logic [7:0] OFS_POS = 8'h24;
    localparam logic [7:0] OFS_SPEED = 8'h28;
    localparam logic [3:0] CMD_HOME = 4'h1;
    localparam logic [3:0] CMD_POS = 4'h2;
    localparam logic [3:0] CMD_SPD = 4'h3;
    localparam logic [3:0] CMD_STOP = 4'h4;
    localparam logic [3:0] CMD_SWSP = 4'h5;
    localparam logic [3:0] CMD_SWPS = 4'h6;
    localparam logic [3:0] CMD_INH = 4'h7;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_AXIS = 8'h01;
    localparam logic [7:0] ERR_BUSY = 8'h02;
    localparam logic [7:0] ERR_INH = 8'h03;
    localparam logic [7:0] ERR_STATE = 8'h04;
    localparam logic [7:0] ERR_CMD = 8'h05;
    localparam logic [2:0] METHOD_MAX = 3'd4;
    localparam logic [15:0] HI_SPD_RST = 16'h0100;
    localparam logic [15:0] LO_SPD_RST = 16'h0010;
    localparam logic [15:0] ACC_RST = 16'h0008;
    localparam logic [15:0] OP_SPD_RST = 16'h0080;
    typedef enum logic [3:0] {
        S_IDLE, S_HIGH, S_DEC, S_LOW, S_REV, S_POS, S_SPD, S_STOP
    } ahs_state_e;
endpackage : ahs_pkg

//--- tb/ahs_machine_model.sv
// machine switches seen by one axis, derived from its position
`timescale 1ns/1ps
`default_nettype none
module ahs_machine_model #(
    parameter int LIM_UP = 40000,
    parameter int LIM_LO = -40000
) (
    // drive side
    input wire logic [31:0] pos_i,
    // switches
    output logic dog_o,
    output logic home_o,
    output logic lim_up_o,
    output logic lim_lo_o
);
    int p;
    always_comb begin
        p = $signed(pos_i);
        // narrow dog: deceleration overshoots it, so reversals see fresh edges
        dog_o = (p >= 10000) && (p <= 11000);
        // windows span many samples at low speed
        home_o = ((p >= 10400) && (p <= 10600)) || ((p >= 12000) && (p <= 13000))
            || ((p >= 17000) && (p <= 18000));
        lim_up_o = p >= LIM_UP;
        lim_lo_o = p <= LIM_LO;
    end
endmodule : ahs_machine_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the axis homing sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ahs_pkg::*;
    localparam int LO_B [5] = '{17000, 10500, 10000, 17800, 39800};
    localparam int HI_B [5] = '{17100, 10600, 10100, 18000, 40000};
    localparam logic [31:0] ERR_CMDW [4] = '{32'h11, 32'h01, 32'h05, 32'h0f};
    // inhibit is refused before an unknown command code is flagged
    localparam logic [7:0] ERR_EXP [4] = '{ERR_AXIS, ERR_INH, ERR_STATE, ERR_INH};
    logic clk, rst, cyc, stb, we, swi, ack, dog, home, lup, llo;
    logic dir, den, busy, done, homed;
    logic [7:0] adr;
    logic [15:0] spd;
    logic [31:0] wdat, rdat, pos, pre_fix, st, p0;
    int errors = 0;
    int n_checks = 0;
    ahs_axis_homing_sequencer dut (.sys_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .dog_i(dog), .home_i(home), .lim_up_i(lup),
        .lim_lo_i(llo), .switch_i(swi), .speed_o(spd), .dir_o(dir), .drive_en_o(den),
        .pos_o(pos), .busy_o(busy), .done_o(done), .homed_o(homed));
    ahs_machine_model mach (.pos_i(pos), .dog_o(dog), .home_o(home), .lim_up_o(lup),
        .lim_lo_o(llo));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // last moving position before the origin was fixed
    always @(posedge clk) if (homed !== 1'b1) pre_fix <= pos;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        st = rdat;
        if (k >= 20) errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wait_idle();
        int k;
        k = 0;
        repeat (3) @(posedge clk);
        while (busy !== 1'b0 && k < 20000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 20000) errors++;
        @(posedge clk);
    endtask : wait_idle
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        {rst, cyc, stb, we, swi, adr, wdat} = {1'b1, 44'h0};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, OFS_HSPD, 32'h0);
        chk(st, {LO_SPD_RST, HI_SPD_RST});
        wb(1'b0, 8'hfc, 32'h0);
        chk(st, 32'h0);
        // refusals while the drive is still inhibited
        foreach (ERR_EXP[i]) begin
            wb(1'b1, OFS_CMD, ERR_CMDW[i]);
            wb(1'b0, OFS_STAT, 32'h0);
            chk({done, st[23:16], st[0]}, {1'b0, ERR_EXP[i], 1'b0});
        end
        wb(1'b1, OFS_CMD, 32'h07);
        repeat (2) @(posedge clk);
        chk({den, done}, 2'b01);
        wb(1'b1, OFS_CMD, 32'h27);
        repeat (2) @(posedge clk);
        chk({den, done}, 2'b11);
        wb(1'b1, OFS_CMD, 32'h0f);
        wb(1'b0, OFS_STAT, 32'h0);
        chk({done, st[23:16]}, {1'b0, ERR_CMD});
        wb(1'b1, OFS_HCFG, 32'h5);
        wb(1'b1, OFS_CMD, {28'h0, CMD_HOME});
        wb(1'b0, OFS_STAT, 32'h0);
        chk(st[23:16], ERR_CMD);
        wb(1'b1, OFS_ORIGIN, 32'h1000);
        foreach (LO_B[i]) begin
            wb(1'b1, OFS_HCFG, 32'(i));
            wb(1'b1, OFS_CMD, {28'h0, CMD_HOME});
            repeat (3) @(posedge clk);
            chk({busy, dir, homed}, 3'b100);
            wait_idle();
            chk(pos, 32'h1000);
            chk({done, homed, spd}, {2'b11, 16'h0});
            // where the fix happened tells which switch edge counted
            chk(32'(pre_fix >= LO_B[i] && pre_fix <= HI_B[i]), 32'h1);
        end
        // move across all origin windows: homed position must survive
        wb(1'b1, OFS_MODE, 32'h0);
        wb(1'b1, OFS_GOAL, 32'd20000);
        wb(1'b1, OFS_CMD, {28'h0, CMD_POS});
        wait_idle();
        chk(pos, 32'd20000);
        chk({homed, done}, 2'b11);
        wb(1'b1, OFS_MODE, 32'h1);
        wb(1'b1, OFS_GOAL, 32'd1000);
        wb(1'b1, OFS_CMD, {28'h0, CMD_POS});
        wait_idle();
        chk(pos, 32'd21000);
        // method 0 backwards: origin edge inside the approach window must not count
        wb(1'b1, OFS_HCFG, 32'h8);
        wb(1'b1, OFS_CMD, {28'h0, CMD_HOME});
        wait_idle();
        chk(pos, 32'h1000);
        chk(32'(pre_fix >= 12000 && pre_fix <= 12100), 32'h1);
        wb(1'b1, OFS_MODE, 32'h0);
        wb(1'b1, OFS_CMD, {28'h0, CMD_SPD});
        repeat (100) @(posedge clk);
        chk({busy, spd}, {1'b1, OP_SPD_RST});
        p0 = pos;
        swi <= 1'b1;
        repeat (6) @(posedge clk);
        swi <= 1'b0;
        wait_idle();
        chk(32'(pos - p0 >= 1000 && pos - p0 <= 1800), 32'h1);
        wb(1'b1, OFS_GOAL, pos + 32'd3000);
        wb(1'b1, OFS_CMD, {28'h0, CMD_POS});
        wb(1'b1, OFS_CMD, {28'h0, CMD_SWPS});
        repeat (100) @(posedge clk);
        chk({busy, spd}, {1'b1, OP_SPD_RST});
        wb(1'b1, OFS_CMD, {28'h0, CMD_HOME});
        wb(1'b0, OFS_STAT, 32'h0);
        chk(st[23:16], ERR_BUSY);
        wb(1'b1, OFS_CMD, {28'h0, CMD_STOP});
        wait_idle();
        chk({done, spd}, {1'b1, 16'h0});
        // reset in mid-motion must drop everything at once
        wb(1'b1, OFS_CMD, {28'h0, CMD_SPD});
        repeat (20) @(posedge clk);
        wb(1'b1, OFS_CMD, {28'h0, CMD_SWSP});
        wb(1'b0, OFS_STAT, 32'h0);
        chk(st[11:8], S_POS);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk({busy, done, homed, den, dir, spd}, 21'h0);
        chk(pos, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
